// [design/pfd_bank.v]
// one bank of feedback divider byte registers for a single pll instance
// assumes the caller decodes the address into a slot and gates wr_en by bank
`timescale 1ns/100ps
`default_nettype none
`include "pfd_consts.vh"

module pfd_bank (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        wr_en,
   input  wire [2:0]  wr_slot,
   input  wire [7:0]  wr_data,
   input  wire [2:0]  rd_slot,
   output wire [7:0]  rd_data,
   output wire [22:0] fb_divider_high,
   output wire [31:0] fb_denominator
);

   reg [7:0] byte_reg [0:`PFD_NUM_SLOTS-1];
   integer   i;

   // ----------------------------------------
   // byte storage
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         for (i = 0; i < `PFD_NUM_SLOTS; i = i + 1) begin
            byte_reg[i] <= `PFD_RST_DIV_BYTE;
         end
         byte_reg[`PFD_SLOT_DEN_BYTE1] <= `PFD_RST_DEN_BYTE1;
      end else if (wr_en) begin
         byte_reg[wr_slot] <= wr_data;
      end
   end

   assign rd_data = byte_reg[rd_slot];

   // bytes concatenate in ascending address order
   assign fb_divider_high = {byte_reg[`PFD_SLOT_DIV_TOP][6:0],
                             byte_reg[`PFD_SLOT_DIV_BYTE10],
                             byte_reg[`PFD_SLOT_DIV_BYTE9]};
   assign fb_denominator  = {byte_reg[`PFD_SLOT_DEN_BYTE4], byte_reg[`PFD_SLOT_DEN_BYTE3],
                             byte_reg[`PFD_SLOT_DEN_BYTE2], byte_reg[`PFD_SLOT_DEN_BYTE1]};

endmodule
`default_nettype wire

// [design/pfd_consts.vh]
// constants for the pll feedback divider register bank
// assumes byte registers on a 32-bit apb word grid (byte address = 4 * index)
`ifndef PFD_CONSTS_VH
`define PFD_CONSTS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define PFD_IDX_DIV_BYTE9     6'h29
`define PFD_IDX_DIV_BYTE10    6'h2A
`define PFD_IDX_DIV_TOP       6'h2B
`define PFD_IDX_DEN_BYTE1     6'h2C
`define PFD_IDX_DEN_BYTE2     6'h2D
`define PFD_IDX_DEN_BYTE3     6'h2E
`define PFD_IDX_DEN_BYTE4     6'h2F
`define PFD_IDX_BANK_SELECT   6'h3C
`define PFD_IDX_STATUS        6'h3D

// ----------------------------------------
// byte slots inside one bank
// ----------------------------------------
`define PFD_SLOT_DIV_BYTE9    3'h0
`define PFD_SLOT_DIV_BYTE10   3'h1
`define PFD_SLOT_DIV_TOP      3'h2
`define PFD_SLOT_DEN_BYTE1    3'h3
`define PFD_SLOT_DEN_BYTE2    3'h4
`define PFD_SLOT_DEN_BYTE3    3'h5
`define PFD_SLOT_DEN_BYTE4    3'h6
`define PFD_NUM_SLOTS         7
`define PFD_SLOT_NONE         4'h8

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PFD_DIV_TOP_MASK      8'h7F
`define PFD_RST_DIV_BYTE      8'h00
`define PFD_RST_DEN_BYTE1     8'h01
`define PFD_RST_DEN_BYTE      8'h00
`define PFD_RST_BANK_SELECT   8'h00
`define PFD_STATUS_DEN_ZERO   0
`define PFD_DIV_HIGH_W        23
`define PFD_DEN_W             32

`endif

// [design/pfd_regs.v]
// apb register bank for the pll feedback divider, one byte bank per pll instance
// assumes an apb master on sys_clk; the pll core reads the per-bank values
// assumes software keeps every denominator nonzero; the zero flag only reports a slip
`timescale 1ns/100ps
`default_nettype none
`include "pfd_consts.vh"

module pfd_regs #(
   parameter NUM_BANKS = 2,
   parameter BANK_W    = 1
) (
   input  wire                               sys_clk,
   input  wire                               sys_rst,
   input  wire                               psel,
   input  wire                               penable,
   input  wire                               pwrite,
   input  wire [7:0]                         paddr,
   input  wire [31:0]                        pwdata,
   output reg  [31:0]                        prdata,
   output reg                                pready,
   output reg                                pslverr,
   output wire [NUM_BANKS*23-1:0]            fb_divider_high_all,
   output wire [NUM_BANKS*32-1:0]            fb_denominator_all,
   output reg  [NUM_BANKS-1:0]               fb_den_zero
);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function [3:0] pfd_slot;
      input [5:0] idx;
      begin
         case (idx)
            `PFD_IDX_DIV_BYTE9:  pfd_slot = {1'b0, `PFD_SLOT_DIV_BYTE9};
            `PFD_IDX_DIV_BYTE10: pfd_slot = {1'b0, `PFD_SLOT_DIV_BYTE10};
            `PFD_IDX_DIV_TOP:    pfd_slot = {1'b0, `PFD_SLOT_DIV_TOP};
            `PFD_IDX_DEN_BYTE1:  pfd_slot = {1'b0, `PFD_SLOT_DEN_BYTE1};
            `PFD_IDX_DEN_BYTE2:  pfd_slot = {1'b0, `PFD_SLOT_DEN_BYTE2};
            `PFD_IDX_DEN_BYTE3:  pfd_slot = {1'b0, `PFD_SLOT_DEN_BYTE3};
            `PFD_IDX_DEN_BYTE4:  pfd_slot = {1'b0, `PFD_SLOT_DEN_BYTE4};
            default:             pfd_slot = `PFD_SLOT_NONE;
         endcase
      end
   endfunction

   // misaligned byte lanes are refused rather than folded onto the word
   reg  [7:0]             bank_select_reg;
   wire [5:0]             reg_idx      = paddr[7:2];
   wire                   aligned      = (paddr[1:0] == 2'h0);
   wire [3:0]             slot         = pfd_slot(reg_idx);
   wire                   is_byte      = aligned && !slot[3];
   wire                   is_bank_sel  = aligned && (reg_idx == `PFD_IDX_BANK_SELECT);
   wire                   is_status    = aligned && (reg_idx == `PFD_IDX_STATUS);
   wire                   bank_ok      = (bank_select_reg < NUM_BANKS);
   wire [BANK_W-1:0]      bank         = bank_select_reg[BANK_W-1:0];
   wire                   access_ok    = (is_byte && bank_ok) || is_bank_sel || (is_status && !pwrite);
   wire                   wr_commit    = psel && penable && pready && pwrite && access_ok;
   wire [7:0]             wr_byte      = (slot[2:0] == `PFD_SLOT_DIV_TOP) ?
                                         (pwdata[7:0] & `PFD_DIV_TOP_MASK) : pwdata[7:0];
   wire [NUM_BANKS*8-1:0] bank_rd_all;

   // ----------------------------------------
   // per-pll byte banks
   // ----------------------------------------
   // the core uses the truncate position only in the remainder-over-denominator form,
   // so the denominator goes out whole and untouched in every case, with no form select here
   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g = g + 1) begin : g_bank
         pfd_bank u_bank (
            .sys_clk         (sys_clk),
            .sys_rst         (sys_rst),
            .wr_en           (wr_commit && is_byte && (bank == g)),
            .wr_slot         (slot[2:0]),
            .wr_data         (wr_byte),
            .rd_slot         (slot[2:0]),
            .rd_data         (bank_rd_all[g*8 +: 8]),
            .fb_divider_high (fb_divider_high_all[g*23 +: 23]),
            .fb_denominator  (fb_denominator_all[g*32 +: 32])
         );
      end
   endgenerate

   // ----------------------------------------
   // bank select register
   // ----------------------------------------
   // any value is stored; one at or above NUM_BANKS parks the byte window so accesses are refused
   reg [7:0] bank_select_next;
   always @* begin
      bank_select_next = bank_select_reg;
      if (wr_commit && is_bank_sel) begin
         bank_select_next = pwdata[7:0];
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         bank_select_reg <= `PFD_RST_BANK_SELECT;
      end else begin
         bank_select_reg <= bank_select_next;
      end
   end

   // ----------------------------------------
   // denominator zero flags
   // ----------------------------------------
   // a zero divisor leaves the pll undefined, so the flag lets the core hold off
   // the flag trails the bytes by one cycle and also sees half-written values
   function pfd_den_is_zero;
      input [`PFD_DEN_W-1:0] den;
      begin
         pfd_den_is_zero = (den == {`PFD_DEN_W{1'b0}});
      end
   endfunction

   reg     [NUM_BANKS-1:0] den_zero_next;
   integer                 b;
   always @* begin
      den_zero_next = {NUM_BANKS{1'b0}};
      for (b = 0; b < NUM_BANKS; b = b + 1) begin
         den_zero_next[b] = pfd_den_is_zero(fb_denominator_all[b*32 +: 32]);
      end
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         fb_den_zero <= {NUM_BANKS{1'b0}};
      end else begin
         fb_den_zero <= den_zero_next;
      end
   end

   // ----------------------------------------
   // read multiplexer
   // ----------------------------------------
   // unmapped and refused reads return zero so no stale byte leaks out
   reg [31:0] rd_word;
   always @* begin
      rd_word = 32'h0000_0000;
      if (is_byte && bank_ok) begin
         rd_word[7:0] = bank_rd_all[bank*8 +: 8];
      end else if (is_bank_sel) begin
         rd_word[7:0] = bank_select_reg;
      end else if (is_status && bank_ok) begin
         rd_word[`PFD_STATUS_DEN_ZERO] = fb_den_zero[bank];
      end
   end

   // ----------------------------------------
   // apb response
   // ----------------------------------------
   // no wait state: the answer is registered at the setup edge so all outputs are flops
   // the price is a fixed second cycle per transfer, which the master sees through pready
   localparam [1:0] RSP_NONE   = 2'h0;
   localparam [1:0] RSP_OKAY   = 2'h1;
   localparam [1:0] RSP_REFUSE = 2'h2;

   reg [1:0]  rsp_kind;
   reg        pready_next;
   reg        pslverr_next;
   reg [31:0] prdata_next;

   // only the setup cycle produces an answer; the access cycle always falls back to none
   always @* begin
      rsp_kind = RSP_NONE;
      if (psel && !penable) begin
         if (access_ok) begin
            rsp_kind = RSP_OKAY;
         end else begin
            rsp_kind = RSP_REFUSE;
         end
      end
   end

   always @* begin
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      prdata_next  = prdata;
      case (rsp_kind)
         RSP_NONE: begin
            pready_next  = 1'b0;
            pslverr_next = 1'b0;
         end
         RSP_OKAY: begin
            pready_next  = 1'b1;
            pslverr_next = 1'b0;
            prdata_next  = pwrite ? 32'h0000_0000 : rd_word;
         end
         RSP_REFUSE: begin
            pready_next  = 1'b1;
            pslverr_next = 1'b1;
            prdata_next  = 32'h0000_0000;
         end
         default: begin
            pready_next  = 1'b0;
            pslverr_next = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= pready_next;
         pslverr <= pslverr_next;
         prdata  <= prdata_next;
      end
   end

endmodule
`default_nettype wire

// [tb/pfd_regs_checker.sv]
// concurrent checks on the apb and value ports of the feedback divider register bank
// assumes two banks and byte addresses of four times the register index
`timescale 1ns/100ps
`default_nettype none
module pfd_regs_checker #(
   parameter NUM_BANKS = 2
) (
   input wire logic                     sys_clk,
   input wire logic                     sys_rst,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [7:0]               paddr,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic [NUM_BANKS*23-1:0]  fb_divider_high_all,
   input wire logic [NUM_BANKS*32-1:0]  fb_denominator_all,
   input wire logic [NUM_BANKS-1:0]     fb_den_zero
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire wr_acc = psel && penable && pready && pwrite && !pslverr;
   sequence s_setup; psel && !penable; endsequence
   sequence s_commit(a); wr_acc && paddr == a; endsequence
   property p_ready; s_setup |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_idle; !psel |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("ready without select");
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_top; pready && !pwrite && paddr == 8'hAC |-> !prdata[7]; endproperty
   a_top: assert property (p_top) else $error("top divider bit7 read high");
   property p_align; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
   a_align: assert property (p_align) else $error("misaligned access accepted");
   property p_den; s_commit(8'hB4) |=> fb_denominator_all[15:8] == $past(pwdata[7:0])
      || fb_denominator_all[47:40] == $past(pwdata[7:0]); endproperty
   a_den: assert property (p_den) else $error("denominator byte2 not applied");
   property p_div; s_commit(8'hAC) |=> fb_divider_high_all[22:16] == $past(pwdata[6:0])
      || fb_divider_high_all[45:39] == $past(pwdata[6:0]); endproperty
   a_div: assert property (p_div) else $error("top divider byte not applied");
   property p_hold; !wr_acc |=> $stable(fb_denominator_all) && $stable(fb_divider_high_all); endproperty
   a_hold: assert property (p_hold) else $error("value changed without write");
   property p_zero; 1'b1 |=> fb_den_zero[0] == ($past(fb_denominator_all[31:0]) == 32'h0); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule
`default_nettype wire

// [tb/test_pll_feedback_divider_regs.sv]
// self-checking apb test of the feedback divider register bank
// assumes nothing about wait states: answers are taken at the edge that samples pready high
`timescale 1ns/100ps
`default_nettype none
`include "pfd_consts.vh"
module test_pll_feedback_divider_regs;
   logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [45:0] fb_divider_high_all;
   logic [63:0] fb_denominator_all;
   logic [1:0]  fb_den_zero;
   integer      fail_count = 0, n_compared = 0, i;
   logic [7:0]  adr [0:6] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hBC};
   pfd_regs #(.NUM_BANKS(2), .BANK_W(1)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fb_divider_high_all(fb_divider_high_all),
      .fb_denominator_all(fb_denominator_all), .fb_den_zero(fb_den_zero));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
      integer n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      // ready, read data and error are all taken at the edge that samples ready high
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         give_verdict();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the write settle before anything looks at the value ports
      @(negedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b1, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b0, 8'h00, q, e);
      chk(q, {56'h0, x});
      chk(e, xe);
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} <= {4'h8, 8'h00, 32'h0};
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 7; i++) rd(adr[i], (i == 3) ? 8'h01 : 8'h00, 1'b0);
      chk(fb_denominator_all, 64'h0000_0001_0000_0001);
      for (i = 0; i < 7; i++) wr(adr[i], 8'hF1 + i);
      // top byte keeps only seven bits, bit7 is dropped
      for (i = 0; i < 7; i++) rd(adr[i], (i == 2) ? 8'h73 : 8'hF1 + i, 1'b0);
      chk(fb_divider_high_all[22:0], {7'h73, 8'hF2, 8'hF1});
      chk(fb_denominator_all[31:0], 32'hF7F6_F5F4);
      wr(8'hF0, 8'h01);
      rd(adr[3], 8'h01, 1'b0);
      wr(adr[2], 8'hFF);
      chk(fb_divider_high_all, {7'h7F, 16'h0000, 7'h73, 8'hF2, 8'hF1});
      wr(adr[6], 8'h80);
      chk(fb_denominator_all, 64'h8000_0001_F7F6_F5F4);
      wr(8'hF0, 8'h00);
      rd(adr[6], 8'hF7, 1'b0);
      for (i = 3; i < 7; i++) wr(adr[i], 8'h00);
      @(negedge sys_clk);
      chk(fb_den_zero, 2'b01);
      rd(8'hF4, 8'h01, 1'b0);
      wr(adr[3], 8'h01);
      @(negedge sys_clk);
      chk(fb_den_zero, 2'b00);
      rd(8'h00, 8'h00, 1'b1);
      rd(8'hA6, 8'h00, 1'b1);
      rd(8'hD0, 8'h00, 1'b1);
      wr(8'hF0, 8'h02);
      wr(adr[0], 8'h55);
      rd(adr[0], 8'h00, 1'b1);
      wr(8'hF0, 8'h00);
      rd(adr[0], 8'hF1, 1'b0);
      give_verdict();
   end
endmodule
bind pfd_regs pfd_regs_checker #(.NUM_BANKS(NUM_BANKS)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fb_divider_high_all(fb_divider_high_all),
   .fb_denominator_all(fb_denominator_all), .fb_den_zero(fb_den_zero));
`default_nettype wire
